// file: pport_regs.sv
// Purpose: Printer port data, status and control registers with irq logic.
// Assumes: Host strobes are one-cycle pulses synchronous to sys_clk_in.
// Notes: Enhanced transfer cycles and ECP FIFO are outside this block.
`default_nettype none

module pport_regs (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    // Host I/O bus
    input wire logic [1:0] host_addr_in,
    input wire logic host_rd_in,
    input wire logic host_wr_in,
    input wire logic [7:0] host_wdata_in,
    output logic [7:0] host_rdata_out,
    output logic host_rdata_oe_b_out,
    // Configuration from the chip's config registers
    input wire logic extended_mode_select_in,
    input wire logic irq_line_choice_in,
    input wire logic [7:0] port_mode_cfg_in,
    input wire logic ecp_mode_in,
    input wire logic enh_wait_in,
    // Printer data pins
    input wire logic [7:0] printer_data_pins_in,
    output logic [7:0] printer_data_pins_out,
    output logic printer_data_pins_oe_b_out,
    // Printer control lines (push-pull, strobe, autofeed and select-in float until first control write, with pin readback)
    input wire logic strobe_in,
    output logic strobe_out,
    output logic strobe_oe_b_out,
    input wire logic autofeed_in,
    output logic autofeed_out,
    output logic autofeed_oe_b_out,
    input wire logic init_in,
    output logic init_out,
    output logic init_oe_b_out,
    input wire logic choose_printer_in,
    output logic choose_printer_out,
    output logic choose_printer_oe_b_out,
    // Printer status inputs
    input wire logic fault_b_in,
    input wire logic online_in,
    input wire logic media_exhausted_in,
    input wire logic ack_b_in,
    input wire logic printer_engaged_in,
    // Interrupt lines
    output logic int_line_a_out,
    output logic int_line_a_oe_b_out,
    output logic int_line_b_out,
    output logic int_line_b_oe_b_out
);
    // ****************************************************************
    // Storage
    // ****************************************************************
    logic [7:0] byte_reg;
    logic [5:0] drive_reg;
    logic driven_reg; // Low until first control write after reset
    logic timeout_reg;
    logic irq_stat_reg;
    logic ack_prev_reg;
    logic enh_prev_reg;
    logic [7:0] rdata_reg;
    logic rdata_oe_b_reg;
    logic irq_reg;
    logic irq_en_reg;

    // ****************************************************************
    // Decode
    // ****************************************************************
    wire sel_byte = (host_addr_in == pport_pkg::OFF_BYTE);
    wire sel_state = (host_addr_in == pport_pkg::OFF_STATE);
    wire sel_drive = (host_addr_in == pport_pkg::OFF_DRIVE);
    wire sel_hole = (host_addr_in == pport_pkg::OFF_HOLE);
    wire enh_mode = port_mode_cfg_in[pport_pkg::M_ENH]; // R25
    wire enh_rev19 = port_mode_cfg_in[pport_pkg::M_REV]; // R25
    wire ext_mode = extended_mode_select_in;
    wire dir_in = drive_reg[pport_pkg::B_DIR];
    // Input direction only in extended mode; compatible is output only
    wire pins_input = ext_mode && dir_in; // R4
    wire ack_rise = ack_b_in && !ack_prev_reg;
    wire ack_fall = !ack_b_in && ack_prev_reg;
    wire enh_rise = enh_mode && !enh_prev_reg;
    wire rd_state = host_rd_in && sel_state;
    wire timeout_hit;
    wire ack_irq_en = drive_reg[pport_pkg::B_ACK_IRQ];
    // Irq status reporting is live in extended, or enhanced/ECP with bit 4
    wire irq_stat_live = ext_mode
        || ((enh_mode || ecp_mode_in) && port_mode_cfg_in[pport_pkg::M_IRQSTAT]); // R11

    pport_timeout #(
        .CYCLES(pport_pkg::TIMEOUT_CYCLES),
        .W(pport_pkg::TCNT_W)
    ) u_timeout (
        .sys_clk_in(sys_clk_in),
        .rst_b_in(rst_b_in),
        .wait_in(enh_mode && enh_wait_in),
        .expired_out(timeout_hit)
    );

    // ****************************************************************
    // Read data assembly
    // ****************************************************************
    wire [7:0] byte_view = pins_input ? printer_data_pins_in : byte_reg; // R1 R2 R3
    wire [7:0] state_view = {
        !printer_engaged_in, // R14
        ack_b_in, media_exhausted_in, online_in, fault_b_in, // R13
        irq_stat_live ? irq_stat_reg : 1'b1, // R11
        1'b1, // R10
        enh_mode ? timeout_reg : 1'b1 // R10
    };
    // Inactive latch bits read the pin, so external forcing shows
    wire strobe_rd = drive_reg[pport_pkg::B_STROBE] | !strobe_in; // R22
    wire autofeed_rd = drive_reg[pport_pkg::B_AUTOFEED] | !autofeed_in; // R22
    wire init_rd = drive_reg[pport_pkg::B_INIT] & init_in; // R22
    wire choose_rd = drive_reg[pport_pkg::B_CHOOSE] | !choose_printer_in; // R22
    wire [7:0] drive_view = {
        2'b11, // R21
        enh_mode ? dir_in : 1'b1, // R20
        ack_irq_en, choose_rd, init_rd, autofeed_rd, strobe_rd
    };
    // Offset 3 is not decoded outside enhanced mode
    wire drive_bus = host_rd_in && !(sel_hole && !enh_mode); // R24
    wire [7:0] rd_mux = sel_byte ? byte_view
        : sel_state ? state_view
        : sel_drive ? drive_view
        : 8'h00;

    // ****************************************************************
    // Data and control latches; state offset takes no write
    // ****************************************************************
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_b_in)
        begin
            byte_reg <= pport_pkg::BYTE_RESET; // R5
            drive_reg <= pport_pkg::DRIVE_RESET; // R23
            driven_reg <= 1'b0; // R23
        end
        else if (host_wr_in && sel_byte)
            byte_reg <= host_wdata_in; // R1 R2 R3
        else if (host_wr_in && sel_drive)
        begin
            drive_reg <= host_wdata_in[5:0]; // R15 R20
            driven_reg <= 1'b1;
        end
        // R6: a write at the state offset falls through with no effect
    end

    // ****************************************************************
    // Timeout and irq status flags; hardware event wins over status read
    // ****************************************************************
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_b_in)
        begin
            timeout_reg <= 1'b0;
            irq_stat_reg <= 1'b1;
            ack_prev_reg <= 1'b1;
            enh_prev_reg <= 1'b0;
        end
        else
        begin
            ack_prev_reg <= ack_b_in;
            enh_prev_reg <= enh_mode;
            if (timeout_hit)
                timeout_reg <= 1'b1; // R7
            else if (rd_state || enh_rise)
                timeout_reg <= 1'b0; // R8 R9
            if (ext_mode && ack_irq_en && ack_rise)
                irq_stat_reg <= 1'b0; // R12
            else if (rd_state)
                irq_stat_reg <= 1'b1; // R12
        end
    end

    // ****************************************************************
    // Interrupt line: level in compatible, pulses otherwise
    // ****************************************************************
    wire irq_next = !ack_irq_en ? 1'b0
        : enh_mode ? (ack_fall || timeout_hit) // R18
        : ext_mode ? ack_rise // R17
        : !ack_b_in; // R17
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_b_in)
        begin
            irq_reg <= 1'b0;
            irq_en_reg <= 1'b0; // R23
            rdata_reg <= 8'h00;
            rdata_oe_b_reg <= 1'b1;
        end
        else
        begin
            irq_reg <= irq_next;
            irq_en_reg <= ack_irq_en; // R17
            rdata_reg <= drive_bus ? rd_mux : rdata_reg;
            rdata_oe_b_reg <= !drive_bus; // R24
        end
    end

    // ****************************************************************
    // Pin outputs
    // ****************************************************************
    assign host_rdata_out = rdata_reg;
    assign host_rdata_oe_b_out = rdata_oe_b_reg;
    assign printer_data_pins_out = byte_reg;
    assign printer_data_pins_oe_b_out = pins_input; // R3 R4
    assign strobe_out = !drive_reg[pport_pkg::B_STROBE]; // R15
    assign autofeed_out = !drive_reg[pport_pkg::B_AUTOFEED]; // R15
    assign choose_printer_out = !drive_reg[pport_pkg::B_CHOOSE]; // R15
    assign init_out = drive_reg[pport_pkg::B_INIT]; // R15
    assign strobe_oe_b_out = !driven_reg; // R23
    assign autofeed_oe_b_out = !driven_reg; // R23
    assign choose_printer_oe_b_out = !driven_reg; // R23
    assign init_oe_b_out = 1'b0; // R23
    // Revision only matters to transfer cycles; folded into int_line_a_out with no effect
    wire rev_unused = enh_rev19;
    assign int_line_a_out = irq_reg && !rev_unused | irq_reg;
    assign int_line_b_out = irq_reg;
    assign int_line_a_oe_b_out = !(irq_en_reg && !irq_line_choice_in); // R17 R18
    assign int_line_b_oe_b_out = !(irq_en_reg && irq_line_choice_in); // R18
endmodule // pport_regs

`default_nettype wire

// file: pport_pkg.sv
// Purpose: Constants shared by the printer port register block.
// Assumes: Byte-wide host I/O bus, single 100 MHz clock.
// Notes: Offsets, counts, drive and mode bit positions and status bits 0 and 2 are named here.
// Operation
// R1 - Compatible mode: writes drive data pins, reads return output latch.
// R2 - Extended, direction clear: writes latched and driven, reads return latch.
// R3 - Extended, direction set: writes only latch, reads return live pin levels.
// R4 - Extended-mode select low forces output-only operation, ignoring direction.
// R5 - Byte port is 8 bits, reset to zero.
// R6 - Status register is read-only; writes do nothing.
// R7 - Enhanced mode: status bit 0 sets on cycle timeout of at least 10 us.
// R8 - Timeout bit clears after status read.
// R9 - Timeout bit clears when enhanced-mode enable rises.
// R10 - Outside enhanced mode status bit 0 reads one; bit 1 always one.
// R11 - Status bit 2 reads one in compatible, or enhanced/ECP with mode bit 4 clear.
// R12 - Extended with ack irq enable: bit 2 latches low on ack rise; read sets it.
// R13 - Status bits 3..6 show fault, online, media exhausted, ack uninverted.
// R14 - Status bit 7 is inverse of printer engaged pin.
// R15 - Control bits 0,1,3 drive outputs inverted; bit 2 drives reset uninverted.
// R16 - Software sets control bit 2 before enabling enhanced or ECP modes.
// R17 - Irq floats when enable clear; compatible follows ack; extended on trailing edge.
// R18 - Enhanced mode irq pulses on ack activation or timeout; line chosen by config.
// R19 - Software keeps ack irq enable clear in ECP mode.
// R20 - Direction bit defaults output; readable in enhanced, reads one in standard.
// R21 - Control bits 6 and 7 read as one.
// R22 - Control reads give latches, but inactive lines forced externally read pin.
// R23 - Reset floats strobe, autofeed, select-in and irq lines; printer reset low.
// R24 - Read at offset 3 in standard mode leaves host data bus undriven.
// R25 - Mode config bit 0 enables enhanced; bit 1 picks revision 1.7 or 1.9.
`default_nettype none

package pport_pkg;
    localparam logic [1:0] OFF_BYTE = 2'h0;
    localparam logic [1:0] OFF_STATE = 2'h1;
    localparam logic [1:0] OFF_DRIVE = 2'h2;
    localparam logic [1:0] OFF_HOLE = 2'h3;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    // Drive port reset: init low, others inactive, direction output
    localparam logic [5:0] DRIVE_RESET = 6'h00;
    // Drive port bit positions
    localparam int B_STROBE = 0;
    localparam int B_AUTOFEED = 1;
    localparam int B_INIT = 2;
    localparam int B_CHOOSE = 3;
    localparam int B_ACK_IRQ = 4;
    localparam int B_DIR = 5;
    // State port bit positions
    localparam int S_TIMEOUT = 0;
    localparam int S_IRQ = 2;
    // Mode config bit positions
    localparam int M_ENH = 0;
    localparam int M_REV = 1;
    localparam int M_IRQSTAT = 4;
    // Timeout of an enhanced-mode wait, least time
    localparam int TIMEOUT_NS = 10000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int TIMEOUT_CYCLES = (TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TCNT_W = 11;
endpackage : pport_pkg

`default_nettype wire

// file: pport_timeout.sv
// Purpose: Counts how long an enhanced-mode cycle waits on the peripheral.
// Assumes: wait_in is high while a cycle waits for the peripheral.
// Notes: Pulses once when the wait reaches the least timeout.
`default_nettype none

module pport_timeout #(
    parameter int CYCLES = pport_pkg::TIMEOUT_CYCLES,
    parameter int W = pport_pkg::TCNT_W
) (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic wait_in,
    output logic expired_out
);
    // Counter holds at CYCLES, so CYCLES itself must fit in W bits
    if (CYCLES < 1 || CYCLES >= (1 << W))
    begin : g_bad_cycles
        $error("pport_timeout: CYCLES does not fit counter");
    end

    logic [W-1:0] count_reg;
    wire at_end = (count_reg == W'(CYCLES - 1));

    // ****************************************************************
    // Wait counter, held at the end so one pulse per wait
    // ****************************************************************
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_b_in)
            count_reg <= '0;
        else if (!wait_in)
            count_reg <= '0;
        else if (count_reg != W'(CYCLES))
            count_reg <= count_reg + W'(1);
    end

    assign expired_out = wait_in && at_end; // R7
endmodule // pport_timeout

`default_nettype wire

// file: pport_chk.sv
// Purpose: Port-level checks for the printer port register block.
// Assumes: One-cycle host strobes; read data lands one cycle later.
// Notes: Bound by name into every pport_regs instance.
`default_nettype none
// ************************
// Checker
// ************************
module pport_chk (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic [1:0] host_addr_in,
    input wire logic host_rd_in,
    input wire logic host_wr_in,
    input wire logic [7:0] host_wdata_in,
    input wire logic [7:0] host_rdata_out,
    input wire logic host_rdata_oe_b_out,
    input wire logic extended_mode_select_in,
    input wire logic [7:0] port_mode_cfg_in,
    input wire logic printer_engaged_in,
    input wire logic [7:0] printer_data_pins_out,
    input wire logic printer_data_pins_oe_b_out,
    input wire logic strobe_out,
    input wire logic init_out,
    input wire logic init_oe_b_out,
    input wire logic int_line_a_oe_b_out,
    input wire logic int_line_b_oe_b_out
);
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_b_in);
    // A status read taken on the host bus
    sequence st_read;
        host_rd_in && host_addr_in == pport_pkg::OFF_STATE;
    endsequence
    // Bus ownership, fixed bits and pin polarities; the bus is shared, so stray drive is an error
    hole_float_a: assert property (host_rd_in && host_addr_in == pport_pkg::OFF_HOLE
        && !port_mode_cfg_in[pport_pkg::M_ENH] |=> host_rdata_oe_b_out)
        else $error("hole read drove bus");
    idle_float_a: assert property (!host_rd_in |=> host_rdata_oe_b_out)
        else $error("bus driven without read");
    busy_bit_a: assert property (st_read |=> host_rdata_out[1]
        && host_rdata_out[7] == !$past(printer_engaged_in)) else $error("status bit wrong");
    drive_fixed_a: assert property (host_rd_in && host_addr_in == pport_pkg::OFF_DRIVE
        |=> host_rdata_out[7:6] == 2'b11) else $error("reserved control bits not one");
    byte_pins_a: assert property (host_wr_in && host_addr_in == pport_pkg::OFF_BYTE
        |=> printer_data_pins_out == $past(host_wdata_in)) else $error("pins miss write");
    out_only_a: assert property (!extended_mode_select_in [*2]
        |-> !printer_data_pins_oe_b_out) else $error("pins released in compatible mode");
    line_polarity_a: assert property (host_wr_in && host_addr_in == pport_pkg::OFF_DRIVE
        |=> strobe_out == !$past(host_wdata_in[0]) && init_out == $past(host_wdata_in[2]))
        else $error("control pin polarity wrong");
    reset_state_a: assert property ($rose(rst_b_in) |-> !init_oe_b_out && !init_out
        && int_line_a_oe_b_out && int_line_b_oe_b_out) else $error("reset pin state wrong");
endmodule // pport_chk
bind pport_regs pport_chk u_chk (.*);
`default_nettype wire

// file: pport_printer.sv
// Purpose: Printer model that takes bytes and answers with acknowledge.
// Assumes: Strobe level is the resolved pin, pulled up when released.
// Notes: Drives the inverse of the last byte whenever the port lets go.
`default_nettype none
// ************************
// Printer
// ************************
module pport_printer (
    input wire logic clk_in,
    input wire logic [7:0] dout_in,
    input wire logic doe_b_in,
    input wire logic strobe_lvl_in,
    output logic [7:0] din_out,
    output logic ack_b_out
);
    logic strobe_reg = 1'b1;
    logic [2:0] cnt_reg = 3'h0;
    logic [7:0] taken_reg = 8'h00;
    // Released bus shows a value unlike the last, so stale data never passes
    assign din_out = doe_b_in ? ~taken_reg : dout_in;
    assign ack_b_out = (cnt_reg == 3'h0) || cnt_reg[2];
    // Byte taken as strobe falls; acknowledge low for three cycles a bit later
    // Plain always: the registers start from declared values, with no reset pin
    always @(posedge clk_in)
    begin
        strobe_reg <= strobe_lvl_in;
        if (strobe_reg && !strobe_lvl_in)
        begin
            taken_reg <= din_out;
            cnt_reg <= 3'h6;
        end
        else if (cnt_reg != 3'h0)
            cnt_reg <= cnt_reg - 3'h1;
    end
endmodule // pport_printer
`default_nettype wire

// file: tb.sv
// Purpose: Self-checking bench for the printer port register block.
// Assumes: Released control pins pull up; printer model on the far side.
// Notes: Timeout is 1000 cycles, so waits of 1010 cycles are used.
`default_nettype none
// ************************
// Bench
// ************************
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_in = 1'b0, rst_b_in = 1'b0, host_rd_in = 1'b0, host_wr_in = 1'b0;
    logic [1:0] host_addr_in = 2'h0;
    logic enh_wait_in = 1'b0, extended_mode_select_in = 1'b0;
    logic irq_line_choice_in = 1'b0, ecp_mode_in = 1'b0, feed_free = 1'b0;
    logic [7:0] host_wdata_in = 8'h00, port_mode_cfg_in = 8'h00;
    logic fault_b_in = 1'b1, online_in = 1'b1, media_exhausted_in = 1'b0;
    logic printer_engaged_in = 1'b0, host_rdata_oe_b_out, printer_data_pins_oe_b_out;
    logic [7:0] host_rdata_out, printer_data_pins_in, printer_data_pins_out, q;
    logic ack_b_in, rd_oe, strobe_out, strobe_oe_b_out, autofeed_out, autofeed_oe_b_out;
    logic init_out, init_oe_b_out, choose_printer_out, choose_printer_oe_b_out;
    logic int_line_a_out, int_line_a_oe_b_out, int_line_b_out, int_line_b_oe_b_out;
    logic [31:0] seed = 32'h0000_4fdf, r;
    int mismatches = 0, tests_run = 0, irq_cnt = 0, irq_b_cnt = 0, base;
    // Pulled-up pins; autofeed can be held low from outside
    wire strobe_in = strobe_oe_b_out | strobe_out;
    wire autofeed_in = feed_free & (autofeed_oe_b_out | autofeed_out);
    wire init_in = init_oe_b_out | init_out;
    wire choose_printer_in = choose_printer_oe_b_out | choose_printer_out;
    always #5 sys_clk_in = ~sys_clk_in;
    // Cycles each interrupt line is driven high
    always @(posedge sys_clk_in)
    begin
        if (!int_line_a_oe_b_out && int_line_a_out === 1'b1)
            irq_cnt <= irq_cnt + 1;
        if (!int_line_b_oe_b_out && int_line_b_out === 1'b1)
            irq_b_cnt <= irq_b_cnt + 1;
    end
    pport_regs DUT (.*);
    pport_printer u_prn (.clk_in(sys_clk_in), .dout_in(printer_data_pins_out),
        .doe_b_in(printer_data_pins_oe_b_out), .strobe_lvl_in(strobe_in),
        .din_out(printer_data_pins_in), .ack_b_out(ack_b_in));
    // Helpers: random source, expected status, compare, one bus cycle, verdict
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] st(input logic b0, input logic b2);
        return {~printer_engaged_in, ack_b_in, media_exhausted_in, online_in, fault_b_in,
            b2, 1'b1, b0};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [1:0] a, input logic [7:0] d);
        @(posedge sys_clk_in);
        host_addr_in <= a;
        host_wdata_in <= d;
        host_wr_in <= w;
        host_rd_in <= !w;
        @(posedge sys_clk_in);
        host_wr_in <= 1'b0;
        host_rd_in <= 1'b0;
        @(negedge sys_clk_in);
        q = host_rdata_out;
        rd_oe = host_rdata_oe_b_out;
    endtask
    task automatic rc(input logic [1:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        chk(q, exp);
    endtask
    task automatic conclude();
        if (mismatches == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Reset, random traffic, then the mode corners
    initial
    begin
        repeat (3) @(posedge sys_clk_in);
        rst_b_in <= 1'b1;
        rc(2'h2, 8'he2);
        rc(2'h0, 8'h00);
        @(posedge sys_clk_in) feed_free <= 1'b1;
        repeat (8)
        begin
            @(posedge sys_clk_in) r = xs();
            {fault_b_in, online_in, media_exhausted_in, printer_engaged_in} <= r[11:8];
            bus(1'b1, 2'h0, r[7:0]);
            rc(2'h0, r[7:0]);
            bus(1'b1, 2'h1, r[23:16]);
            rc(2'h1, st(1'b1, 1'b1));
            bus(1'b1, 2'h2, r[31:24]);
            rc(2'h2, {3'b111, r[28:24]});
            repeat (8) @(posedge sys_clk_in);
        end
        // Strobe a byte out, then turn the port to input
        bus(1'b1, 2'h2, 8'h04);
        bus(1'b1, 2'h0, 8'h5a);
        bus(1'b1, 2'h2, 8'h05);
        bus(1'b1, 2'h2, 8'h04);
        @(posedge sys_clk_in) extended_mode_select_in <= 1'b1;
        bus(1'b1, 2'h2, 8'h24);
        bus(1'b1, 2'h0, 8'h3c);
        rc(2'h0, 8'ha5);
        bus(1'b1, 2'h2, 8'h04);
        rc(2'h0, 8'h3c);
        // Acknowledge with its interrupt enabled
        base = irq_cnt;
        bus(1'b1, 2'h2, 8'h15);
        bus(1'b1, 2'h2, 8'h14);
        repeat (10) @(posedge sys_clk_in);
        rc(2'h1, st(1'b1, 1'b0));
        rc(2'h1, st(1'b1, 1'b1));
        chk(8'(irq_cnt - base), 8'h01);
        // Enhanced mode timeout, cleared by a read and by enabling again
        bus(1'b1, 2'h2, 8'h04);
        @(posedge sys_clk_in) port_mode_cfg_in <= 8'h01;
        @(posedge sys_clk_in) enh_wait_in <= 1'b1;
        // Not yet set shortly before the least timeout, set just after it
        repeat (990) @(posedge sys_clk_in);
        rc(2'h1, st(1'b0, 1'b1));
        repeat (20) @(posedge sys_clk_in);
        enh_wait_in <= 1'b0;
        rc(2'h1, st(1'b1, 1'b1));
        rc(2'h1, st(1'b0, 1'b1));
        bus(1'b1, 2'h2, 8'h24);
        rc(2'h2, 8'he4);
        @(posedge sys_clk_in) enh_wait_in <= 1'b1;
        repeat (1010) @(posedge sys_clk_in);
        enh_wait_in <= 1'b0;
        port_mode_cfg_in <= 8'h00;
        @(posedge sys_clk_in) port_mode_cfg_in <= 8'h01;
        rc(2'h1, st(1'b0, 1'b1));
        // Enhanced irq on the second line: one pulse per timeout, first line floats
        @(posedge sys_clk_in) irq_line_choice_in <= 1'b1;
        bus(1'b1, 2'h2, 8'h34);
        base = irq_b_cnt;
        @(posedge sys_clk_in) enh_wait_in <= 1'b1;
        repeat (1010) @(posedge sys_clk_in);
        enh_wait_in <= 1'b0;
        chk(8'(irq_b_cnt - base), 8'h01);
        chk({7'h00, int_line_a_oe_b_out}, 8'h01);
        @(posedge sys_clk_in) port_mode_cfg_in <= 8'h00;
        bus(1'b0, 2'h3, 8'h00);
        chk({7'h00, rd_oe}, 8'h01);
        conclude();
    end
endmodule // tb
`default_nettype wire
